// ==== common/temp_slave_regs.svh ====
// Purpose: constants of the two-wire register slave
// Assumes: included by bare name; definitions only
// Notes: limit reset values are plain defaults
//
// Contract
// - pointer byte upper six bits are zero
// - pointer 00 temp, 01 cfg, 10 hyst, 11 tos
// - every byte shifts most significant bit first
// - device is slave only, never drives clock
// - repeated start begins a new transfer
// - receiver pulls data low for acknowledge
// - first byte is address plus direction bit
// - address decoded from three tri-state straps
// - data changes only while clock is low
// - byte takes eight bits plus acknowledge
// - write is address, pointer, then data bytes
// - config write one byte, limits two bytes
// - byte 0x54 after write address resets device
// - read data starts right after address acknowledge
// - config read is one byte then NACK
// - two-byte reads: ACK first, NACK second
// - NACK after upper byte ends transmission
// - new read pointer needs write then restart
// - idle bus leaves both lines high
// - pointer kept across transactions for reads
// - reset selects the temperature register
`ifndef TEMP_SLAVE_REGS_SVH
`define TEMP_SLAVE_REGS_SVH

`define PTR_TEMP      2'h0
`define PTR_CFG       2'h1
`define PTR_HYST      2'h2
`define PTR_TOS       2'h3
`define SOFT_POR_CMD  8'h54
`define BIT_LAST      4'h7
`define ACK_SLOT      4'h8
`define CFG_RESET     7'h00
`define HYST_RESET    16'h0000
`define TOS_RESET     16'h0000
`define STRAP_FLOAT   2'h2
`define ADDR_DEFAULT  7'h48

`endif

// ==== common/temp_slave_pkg.sv ====
// Purpose: types of the two-wire register slave
// Assumes: nothing
// Notes: none
package temp_slave_pkg;
   typedef enum logic [2:0] {st_idle, st_addr, st_ptr, st_wdata, st_read, st_ignore} slave_state_e;
   typedef logic [1:0] strap_t;
endpackage

// ==== core/two_wire_register_slave.sv ====
// Purpose: two-wire slave with pointer and three writable registers
// Assumes: scl is the link clock; bus hold times far exceed flop delays
// Notes: strap bit 1 flags a floating pin, bit 0 gives its level
`timescale 1ns/100ps
`include "temp_slave_regs.svh"

module two_wire_register_slave (
   input  wire logic                  mclk,             // system clock
   input  wire logic                  rst,              // async reset, high
   input  wire logic                  scl,              // bus clock from master
   input  wire logic                  sda_in,           // data line level
   output logic                       sda_out,          // data line drive value
   output logic                       sda_oe,           // data line pulled low when high
   input  wire temp_slave_pkg::strap_t addr_strap_zero, // strap pin 0
   input  wire temp_slave_pkg::strap_t addr_strap_one,  // strap pin 1
   input  wire temp_slave_pkg::strap_t addr_strap_two,  // strap pin 2
   input  wire logic [15:0]           temp_value,       // current temperature
   output logic [7:0]                 config_out,       // configuration register
   output logic [15:0]                hyst_out,         // hysteresis_limit register
   output logic [15:0]                tos_out,          // overtemperature limit
   output logic                       sw_reset,         // one-cycle soft reset pulse
   output logic                       bus_busy          // between start and stop
);

   temp_slave_pkg::slave_state_e st;
   logic       start_tgl;
   logic       stop_tgl;
   logic       start_seen;
   logic       stop_seen;
   logic       new_start;
   logic       new_stop;
   logic       new_ev;
   logic [5:0] strap_m;
   logic [5:0] strap_s;
   logic [6:0] my_addr;
   logic [3:0] bit_cnt;
   logic [7:0] shreg;
   logic [7:0] rx_byte;
   logic       rx_ack;
   logic       ack_pend;
   logic [1:0] byte_idx;
   logic       is_por;
   logic       data_ok;
   logic [1:0] pointer;
   logic [6:0] cfg;
   logic [15:0] hyst;
   logic [15:0] tos;
   logic [7:0] wr_hi;
   logic [7:0] tx;
   logic       upd_tgl;
   logic       swr_tgl;
   logic       treq;
   logic       treq_m;
   logic       treq_s;
   logic       tack;
   logic       tack_m;
   logic       tack_s;
   logic [15:0] temp_hold;
   logic [15:0] temp_shadow;
   logic       upd_m;
   logic       upd_s;
   logic       upd_d;
   logic       swr_m;
   logic       swr_s;
   logic       swr_d;
   logic       sta_m;
   logic       sta_s;
   logic       sta_d;
   logic       sto_m;
   logic       sto_s;
   logic       sto_d;

   function automatic logic [1:0] norm_strap(input logic [1:0] s);
      norm_strap = s[1] ? `STRAP_FLOAT : {1'b0, s[0]};
   endfunction

   function automatic logic [6:0] strap_addr(input logic [5:0] k);
      case (k)
         6'h00: strap_addr = 7'h48;
         6'h01: strap_addr = 7'h49;
         6'h04: strap_addr = 7'h4A;
         6'h05: strap_addr = 7'h4B;
         6'h02: strap_addr = 7'h2C;
         6'h08: strap_addr = 7'h28;
         6'h06: strap_addr = 7'h2D;
         6'h09: strap_addr = 7'h29;
         6'h0A: strap_addr = 7'h35;
         6'h10: strap_addr = 7'h4C;
         6'h11: strap_addr = 7'h4D;
         6'h14: strap_addr = 7'h4E;
         6'h15: strap_addr = 7'h4F;
         6'h12: strap_addr = 7'h2E;
         6'h18: strap_addr = 7'h2A;
         6'h16: strap_addr = 7'h2F;
         6'h19: strap_addr = 7'h2B;
         6'h1A: strap_addr = 7'h36;
         6'h20: strap_addr = 7'h70;
         6'h21: strap_addr = 7'h72;
         6'h24: strap_addr = 7'h73;
         6'h25: strap_addr = 7'h75;
         6'h22: strap_addr = 7'h71;
         6'h28: strap_addr = 7'h76;
         6'h26: strap_addr = 7'h74;
         6'h29: strap_addr = 7'h77;
         6'h2A: strap_addr = 7'h37;
         default: strap_addr = `ADDR_DEFAULT;
      endcase
   endfunction

   // register byte for a read; lo picks the lower byte of 16-bit registers
   function automatic logic [7:0] read_byte(input logic [1:0] p, input logic lo);
      logic [15:0] w;
      w = 16'h0000;
      case (p)
         `PTR_TEMP: w = temp_shadow;
         `PTR_HYST: w = hyst;
         `PTR_TOS:  w = tos;
         default:   w = {1'b0, cfg, 1'b0, cfg};
      endcase
      read_byte = lo ? w[7:0] : w[15:8];
   endfunction

   // start and stop detectors run on data-line edges while scl is high
   always_ff @(negedge sda_in or posedge rst)
   begin
      if (rst)
         start_tgl <= 1'b0;
      else if (scl)
         start_tgl <= ~start_tgl;
   end

   always_ff @(posedge sda_in or posedge rst)
   begin
      if (rst)
         stop_tgl <= 1'b0;
      else if (scl)
         stop_tgl <= ~stop_tgl;
   end

   // toggles settle while scl is high, long before the next rising edge
   assign new_start = start_tgl != start_seen;
   assign new_stop  = stop_tgl != stop_seen;
   assign new_ev    = new_start | new_stop;

   always_ff @(posedge scl or posedge rst)
   begin
      if (rst)
      begin
         strap_m <= 6'h00;
         strap_s <= 6'h00;
      end
      else
      begin
         strap_m <= {addr_strap_two, addr_strap_one, addr_strap_zero};
         strap_s <= strap_m;
      end
   end

   assign my_addr = strap_addr({norm_strap(strap_s[5:4]), norm_strap(strap_s[3:2]),
                                norm_strap(strap_s[1:0])});

   assign rx_byte = {shreg[6:0], sda_in};
   assign is_por  = st == temp_slave_pkg::st_ptr && rx_byte == `SOFT_POR_CMD;
   assign data_ok = pointer == `PTR_CFG ? byte_idx == 2'h0 :
                    pointer != `PTR_TEMP && byte_idx[1] == 1'b0;

   always_comb
   begin
      case (st)
         temp_slave_pkg::st_addr:  rx_ack = rx_byte[7:1] == my_addr;
         temp_slave_pkg::st_ptr:   rx_ack = !is_por;
         temp_slave_pkg::st_wdata: rx_ack = data_ok;
         default:                  rx_ack = 1'b0;
      endcase
   end

   // protocol sequencer
   always_ff @(posedge scl or posedge rst)
   begin
      if (rst)
      begin
         st         <= temp_slave_pkg::st_idle;
         bit_cnt    <= 4'h0;
         shreg      <= 8'h00;
         ack_pend   <= 1'b0;
         byte_idx   <= 2'h0;
         start_seen <= 1'b0;
         stop_seen  <= 1'b0;
      end
      else if (new_start)
      begin
         start_seen <= start_tgl;
         stop_seen  <= stop_tgl;
         st         <= temp_slave_pkg::st_addr;
         bit_cnt    <= 4'h1;
         shreg      <= {7'h00, sda_in};
         ack_pend   <= 1'b0;
         byte_idx   <= 2'h0;
      end
      else if (new_stop)
      begin
         stop_seen <= stop_tgl;
         st        <= temp_slave_pkg::st_idle;
         bit_cnt   <= 4'h0;
         ack_pend  <= 1'b0;
      end
      else
      begin
         case (st)
            temp_slave_pkg::st_addr, temp_slave_pkg::st_ptr, temp_slave_pkg::st_wdata:
            begin
               if (bit_cnt < `ACK_SLOT)
               begin
                  shreg   <= rx_byte;
                  bit_cnt <= bit_cnt + 4'h1;
               end
               if (bit_cnt == `BIT_LAST)
               begin
                  ack_pend <= rx_ack;
                  if ((st == temp_slave_pkg::st_addr && !rx_ack) || is_por)
                     st <= temp_slave_pkg::st_ignore;
               end
               if (bit_cnt == `ACK_SLOT)
               begin
                  bit_cnt  <= 4'h0;
                  ack_pend <= 1'b0;
                  if (st == temp_slave_pkg::st_addr)
                  begin
                     byte_idx <= 2'h0;
                     st <= shreg[0] ? temp_slave_pkg::st_read : temp_slave_pkg::st_ptr;
                  end
                  else if (st == temp_slave_pkg::st_ptr)
                  begin
                     byte_idx <= 2'h0;
                     st       <= temp_slave_pkg::st_wdata;
                  end
                  else if (byte_idx != 2'h3)
                     byte_idx <= byte_idx + 2'h1;
               end
            end
            temp_slave_pkg::st_read:
            begin
               if (bit_cnt < `ACK_SLOT)
                  bit_cnt <= bit_cnt + 4'h1;
               else
               begin
                  bit_cnt <= 4'h0;
                  if (sda_in)
                     st <= temp_slave_pkg::st_ignore;
                  else
                     byte_idx <= byte_idx + 2'h1;
               end
            end
            default:
            begin
               bit_cnt <= 4'h0;
            end
         endcase
      end
   end

   // pointer and register storage
   always_ff @(posedge scl or posedge rst)
   begin
      if (rst)
      begin
         pointer <= `PTR_TEMP;
         cfg     <= `CFG_RESET;
         hyst    <= `HYST_RESET;
         tos     <= `TOS_RESET;
         wr_hi   <= 8'h00;
         upd_tgl <= 1'b0;
         swr_tgl <= 1'b0;
      end
      else if (!new_ev && bit_cnt == `BIT_LAST && st == temp_slave_pkg::st_ptr)
      begin
         if (is_por)
         begin
            pointer <= `PTR_TEMP;
            cfg     <= `CFG_RESET;
            hyst    <= `HYST_RESET;
            tos     <= `TOS_RESET;
            wr_hi   <= 8'h00;
            upd_tgl <= ~upd_tgl;
            swr_tgl <= ~swr_tgl;
         end
         else
            pointer <= rx_byte[1:0];
      end
      else if (!new_ev && bit_cnt == `BIT_LAST && st == temp_slave_pkg::st_wdata && data_ok)
      begin
         case (pointer)
            `PTR_CFG:
            begin
               cfg     <= rx_byte[6:0];
               upd_tgl <= ~upd_tgl;
            end
            `PTR_HYST, `PTR_TOS:
            begin
               if (byte_idx == 2'h0)
                  wr_hi <= rx_byte;
               else
               begin
                  if (pointer == `PTR_HYST)
                     hyst <= {wr_hi, rx_byte};
                  else
                     tos <= {wr_hi, rx_byte};
                  upd_tgl <= ~upd_tgl;
               end
            end
            default:
            begin
               wr_hi <= wr_hi;
            end
         endcase
      end
   end

   // transmit shifter, loaded at each acknowledge slot of a read
   always_ff @(posedge scl or posedge rst)
   begin
      if (rst)
         tx <= 8'h00;
      else if (!new_ev && st == temp_slave_pkg::st_addr && bit_cnt == `ACK_SLOT && shreg[0])
         tx <= read_byte(pointer, 1'b0);
      else if (!new_ev && st == temp_slave_pkg::st_read && bit_cnt == `ACK_SLOT)
         tx <= read_byte(pointer, ~byte_idx[0]);
      else if (!new_ev && st == temp_slave_pkg::st_read)
         tx <= {tx[6:0], 1'b0};
   end

   // data line changes only on falling scl
   always_ff @(negedge scl or posedge rst)
   begin
      if (rst)
         sda_oe <= 1'b0;
      else if (new_ev)
         sda_oe <= 1'b0;
      else
      begin
         case (st)
            temp_slave_pkg::st_read:
               sda_oe <= bit_cnt < `ACK_SLOT && !tx[7];
            temp_slave_pkg::st_addr, temp_slave_pkg::st_ptr, temp_slave_pkg::st_wdata:
               sda_oe <= bit_cnt == `ACK_SLOT && ack_pend;
            default:
               sda_oe <= 1'b0;
         endcase
      end
   end

   // open drain only: never drives high and has no clock output
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         sda_out <= 1'b0;
      else
         sda_out <= 1'b0;
   end

   // temperature crosses into the link domain by request/acknowledge toggles
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         tack_m    <= 1'b0;
         tack_s    <= 1'b0;
         treq      <= 1'b0;
         temp_hold <= 16'h0000;
      end
      else
      begin
         tack_m <= tack;
         tack_s <= tack_m;
         if (tack_s == treq)
         begin
            temp_hold <= temp_value;
            treq      <= ~treq;
         end
      end
   end

   always_ff @(posedge scl or posedge rst)
   begin
      if (rst)
      begin
         treq_m      <= 1'b0;
         treq_s      <= 1'b0;
         tack        <= 1'b0;
         temp_shadow <= 16'h0000;
      end
      else
      begin
         treq_m <= treq;
         treq_s <= treq_m;
         // held off in the read state only, so an update on the address acknowledge edge can split the two bytes
         if (treq_s != tack && st != temp_slave_pkg::st_read)
         begin
            temp_shadow <= temp_hold;
            tack        <= treq_s;
         end
      end
   end

   // register values and soft reset cross back to the system clock
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         upd_m      <= 1'b0;
         upd_s      <= 1'b0;
         upd_d      <= 1'b0;
         swr_m      <= 1'b0;
         swr_s      <= 1'b0;
         swr_d      <= 1'b0;
         sw_reset   <= 1'b0;
         config_out <= {1'b0, `CFG_RESET};
         hyst_out   <= `HYST_RESET;
         tos_out    <= `TOS_RESET;
      end
      else
      begin
         upd_m    <= upd_tgl;
         upd_s    <= upd_m;
         upd_d    <= upd_s;
         swr_m    <= swr_tgl;
         swr_s    <= swr_m;
         swr_d    <= swr_s;
         sw_reset <= swr_s ^ swr_d;
         if (upd_s != upd_d)
         begin
            config_out <= {1'b0, cfg};
            hyst_out   <= hyst;
            tos_out    <= tos;
         end
      end
   end

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         sta_m    <= 1'b0;
         sta_s    <= 1'b0;
         sta_d    <= 1'b0;
         sto_m    <= 1'b0;
         sto_s    <= 1'b0;
         sto_d    <= 1'b0;
         bus_busy <= 1'b0;
      end
      else
      begin
         sta_m <= start_tgl;
         sta_s <= sta_m;
         sta_d <= sta_s;
         sto_m <= stop_tgl;
         sto_s <= sto_m;
         sto_d <= sto_s;
         if (sta_s != sta_d)
            bus_busy <= 1'b1;
         else if (sto_s != sto_d)
            bus_busy <= 1'b0;
      end
   end

   a_start_restart: assert property (@(posedge scl) disable iff (rst)
      new_start |=> st == temp_slave_pkg::st_addr && bit_cnt == 4'h1)
      else $error("start did not restart address phase");
   a_msb_first_out: assert property (@(posedge scl) disable iff (rst)
      st == temp_slave_pkg::st_read && bit_cnt < 4'h8 && !new_ev |-> sda_oe == !tx[7])
      else $error("read bit not driven from transmit msb");
   a_ack_drive: assert property (@(posedge scl) disable iff (rst)
      st != temp_slave_pkg::st_read && st != temp_slave_pkg::st_idle && bit_cnt == 4'h8 && ack_pend |-> sda_oe)
      else $error("acknowledge not driven");
   a_bit_count: assert property (@(posedge scl) disable iff (rst)
      bit_cnt <= 4'h8)
      else $error("bit counter beyond acknowledge slot");
   a_addr_mismatch: assert property (@(posedge scl) disable iff (rst)
      st == temp_slave_pkg::st_addr && bit_cnt == 4'h7 && !new_ev && rx_byte[7:1] != my_addr
      |=> st == temp_slave_pkg::st_ignore ##1 !sda_oe)
      else $error("foreign address not ignored");
   a_soft_por: assert property (@(posedge scl) disable iff (rst)
      st == temp_slave_pkg::st_ptr && bit_cnt == 4'h7 && !new_ev && rx_byte == 8'h54
      |=> pointer == 2'h0 && st == temp_slave_pkg::st_ignore ##1 !sda_oe)
      else $error("soft reset command mishandled");
   a_read_start: assert property (@(posedge scl) disable iff (rst)
      st == temp_slave_pkg::st_addr && bit_cnt == 4'h8 && ack_pend && shreg[0] && !new_ev
      |=> st == temp_slave_pkg::st_read && bit_cnt == 4'h0 && tx == read_byte(pointer, 1'b0))
      else $error("read did not start after address acknowledge");
   a_nack_ends: assert property (@(posedge scl) disable iff (rst)
      st == temp_slave_pkg::st_read && bit_cnt == 4'h8 && sda_in && !new_ev |=> st == temp_slave_pkg::st_ignore)
      else $error("transmission continued after master NACK");
   a_ptr_stable: assert property (@(posedge scl) disable iff (rst)
      st == temp_slave_pkg::st_read && $past(st) == temp_slave_pkg::st_read |-> $stable(pointer))
      else $error("pointer changed during a read");
   a_cfg_write: assert property (@(posedge scl) disable iff (rst)
      st == temp_slave_pkg::st_wdata && bit_cnt == 4'h7 && !new_ev && pointer == 2'h1 && byte_idx == 2'h0
      |=> cfg == $past(rx_byte[6:0]))
      else $error("configuration write lost");

   c_write_cfg: cover property (@(posedge scl) disable iff (rst)
      st == temp_slave_pkg::st_wdata && pointer == 2'h1 && bit_cnt == 4'h8 && ack_pend);
   c_two_byte_read: cover property (@(posedge scl) disable iff (rst)
      st == temp_slave_pkg::st_read && byte_idx == 2'h1 && bit_cnt == 4'h8);
   c_soft_reset: cover property (@(posedge mclk) disable iff (rst) sw_reset);
   c_ignored: cover property (@(posedge scl) disable iff (rst) st == temp_slave_pkg::st_ignore);

endmodule

// ==== testbench/i2c_master_model.sv ====
// Purpose: bus master model driving the two-wire slave
// Assumes: data line is open drain with a pull-up
// Notes: bus clock stands high between frames, 30 ns period inside
`timescale 1ns/100ps

module i2c_master_model (
   output logic      scl,     // bus clock
   output logic      sda_low, // pulls the data line low
   input  wire logic sda      // resolved data line
);
   localparam realtime Q = 7.5;

   initial
   begin
      scl = 1'b1;
      sda_low = 1'b0;
   end

   task automatic start();
      if (!scl)
      begin
         #Q sda_low = 1'b0;
         #Q scl = 1'b1;
      end
      #Q sda_low = 1'b1;
      #Q scl = 1'b0;
   endtask

   task automatic stop();
      #Q sda_low = 1'b1;
      #Q scl = 1'b1;
      #Q sda_low = 1'b0;
      #Q;
   endtask

   // data moves only while the clock is low
   task automatic bit_io(input logic b, output logic r);
      #Q sda_low = !b;
      #Q scl = 1'b1;
      r = sda;
      #(2 * Q) scl = 1'b0;
   endtask

   task automatic wr_byte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--)
         bit_io(d[i], r);
      bit_io(1'b1, ack);
   endtask

   task automatic rd_byte(input logic last, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--)
         bit_io(1'b1, d[i]);
      bit_io(last, r);
   endtask
endmodule

// ==== testbench/two_wire_register_slave_tb.sv ====
// Purpose: self-checking bench of the two-wire register slave
// Assumes: master model owns the bus clock
// Notes: straps change only between frames
`timescale 1ns/100ps
`include "temp_slave_regs.svh"

module two_wire_register_slave_tb;
   logic                   mclk = 1'b0;
   logic                   rst = 1'b1;
   logic                   scl;
   logic                   m_low;
   logic                   sda;
   logic                   sda_out;
   logic                   sda_oe;
   temp_slave_pkg::strap_t s0 = 2'h0;
   temp_slave_pkg::strap_t s1 = 2'h0;
   temp_slave_pkg::strap_t s2 = 2'h0;
   logic [15:0]            temp = 16'hC3A5;
   logic [7:0]             config_out;
   logic [15:0]            hyst_out;
   logic [15:0]            tos_out;
   logic                   sw_reset;
   logic                   bus_busy;
   logic [15:0]            n_swr = 16'h0000;
   int                     n_mismatch = 0;
   int                     checks_done = 0;

   // pull-up wins unless someone pulls low
   assign sda = ~(m_low | (sda_oe & ~sda_out));

   always #20 mclk = ~mclk;

   always @(posedge mclk)
      if (sw_reset === 1'b1)
         n_swr <= n_swr + 16'h0001;

   i2c_master_model u_master (.scl, .sda_low(m_low), .sda);

   two_wire_register_slave u_dut (
      .mclk, .rst, .scl, .sda_in(sda), .sda_out, .sda_oe,
      .addr_strap_zero(s0), .addr_strap_one(s1), .addr_strap_two(s2),
      .temp_value(temp), .config_out, .hyst_out, .tos_out, .sw_reset, .bus_busy
   );

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic wr(input logic [6:0] a, input logic [7:0] p, input int n,
                     input logic [15:0] d, output logic [3:0] k);
      k = 4'h0;
      u_master.start();
      u_master.wr_byte({a, 1'b0}, k[3]);
      u_master.wr_byte(p, k[2]);
      for (int i = 0; i < n; i++)
         u_master.wr_byte(d[15 - 8 * i -: 8], k[1 - i]);
      u_master.stop();
      repeat (8) @(posedge mclk);
   endtask

   task automatic rd(input logic [6:0] a, input logic setp, input logic [1:0] p,
                     input int n, output logic [15:0] d, output logic ack);
      logic x;
      d = 16'h0000;
      if (setp)
      begin
         u_master.start();
         u_master.wr_byte({a, 1'b0}, x);
         u_master.wr_byte({6'h00, p}, x);
      end
      u_master.start();
      u_master.wr_byte({a, 1'b1}, ack);
      for (int i = 0; i < n; i++)
         u_master.rd_byte(i == n - 1, d[15 - 8 * i -: 8]);
      u_master.stop();
      repeat (4) @(posedge mclk);
   endtask

   task automatic t_power_up();
      logic [15:0] d;
      logic        a;
      chk({8'h00, config_out}, 16'h0000);
      chk(hyst_out | tos_out, 16'h0000);
      chk(16'({sda_oe, bus_busy, sda_out}), 16'h0000);
      rd(`ADDR_DEFAULT, 1'b0, 2'h0, 2, d, a);
      chk(16'(a), 16'h0000);
      chk(d, 16'hC3A5);
   endtask

   task automatic t_writes();
      logic [3:0] k;
      wr(`ADDR_DEFAULT, {6'h00, `PTR_TEMP}, 1, 16'h1200, k);
      chk(16'(k), 16'h0002);
      wr(`ADDR_DEFAULT, {6'h00, `PTR_CFG}, 1, 16'hFF00, k);
      chk(16'(k), 16'h0000);
      chk({8'h00, config_out}, 16'h007F);
      wr(`ADDR_DEFAULT, {6'h00, `PTR_HYST}, 2, 16'hA55A, k);
      chk(16'(k), 16'h0000);
      chk(hyst_out, 16'hA55A);
      wr(`ADDR_DEFAULT, {6'h00, `PTR_TOS}, 2, 16'h5AA5, k);
      chk(tos_out, 16'h5AA5);
   endtask

   task automatic t_pointers();
      logic [15:0] d;
      logic        a;
      logic [15:0] exp [4] = '{16'hC3A5, 16'h7F00, 16'hA55A, 16'h5AA5};
      for (int p = 0; p < 4; p++)
      begin
         rd(`ADDR_DEFAULT, 1'b1, 2'(p), (p == 1) ? 1 : 2, d, a);
         chk(d, exp[p]);
      end
      rd(`ADDR_DEFAULT, 1'b0, 2'h0, 1, d, a);
      chk(d, 16'h5A00);
      chk(16'({sda, sda_oe, bus_busy}), 16'h0004);
   endtask

   task automatic t_foreign();
      logic [3:0]  k;
      logic [15:0] d;
      logic        a;
      wr(7'h49, {6'h00, `PTR_CFG}, 1, 16'h0000, k);
      chk(16'(k), 16'h000E);
      chk({8'h00, config_out}, 16'h007F);
      rd(7'h49, 1'b0, 2'h0, 1, d, a);
      chk(d, 16'hFF00);
      chk(16'(a), 16'h0001);
   endtask

   task automatic t_straps();
      logic [15:0] d;
      logic        a;
      logic [5:0]  pins [3] = '{6'b10_10_10, 6'b01_00_10, 6'b00_00_00};
      logic [6:0]  addr [3] = '{7'h37, 7'h2E, 7'h48};
      for (int i = 0; i < 3; i++)
      begin
         @(posedge mclk);
         {s2, s1, s0} <= pins[i];
         repeat (4) @(posedge mclk);
         rd(addr[i], 1'b0, 2'h0, 1, d, a);
         chk(16'(a), 16'h0000);
      end
   endtask

   task automatic t_soft_por();
      logic [3:0]  k;
      logic [15:0] d;
      logic        a;
      wr(`ADDR_DEFAULT, 8'h54, 0, 16'h0000, k);
      chk(16'(k), 16'h0004);
      chk(n_swr, 16'h0001);
      chk({8'h00, config_out} | hyst_out, 16'h0000);
      rd(`ADDR_DEFAULT, 1'b0, 2'h0, 2, d, a);
      chk(d, 16'hC3A5);
   endtask

   initial
   begin
      #400_000;
      n_mismatch++;
      end_of_test();
   end

   initial
   begin
      repeat (12) @(posedge mclk);
      rst <= 1'b0;
      repeat (4) @(posedge mclk);
      t_power_up();
      t_writes();
      t_pointers();
      t_foreign();
      t_straps();
      t_soft_por();
      end_of_test();
   end
endmodule
